// ### dftm_pkg.sv
// Shared constants and types for the defect table access block
package dftm_pkg;
    // APB geometry
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    // Register byte offsets
    localparam logic [APB_AW-1:0] OFS_COMMAND = 8'h00;
    localparam logic [APB_AW-1:0] OFS_VPOS = 8'h04;
    localparam logic [APB_AW-1:0] OFS_HPOS = 8'h08;
    localparam logic [APB_AW-1:0] OFS_LVL_ON = 8'h0c;
    localparam logic [APB_AW-1:0] OFS_LVL_ABOVE = 8'h10;
    localparam logic [APB_AW-1:0] OFS_LVL_BELOW = 8'h14;
    localparam logic [APB_AW-1:0] OFS_LEVEL_SHIFT = 8'h18;
    // Command register bit positions
    localparam int CMD_WR_BIT = 0;
    localparam int CMD_RD_BIT = 1;
    localparam int CMD_ARST_BIT = 2;
    localparam int CMD_CLR_BIT = 4;
    // Field widths
    localparam int POS_W = 12;
    localparam int LEVEL_W = 8;
    localparam int SHIFT_W = 3;
    localparam int PIX_W = 14;
    // Reset values
    localparam logic [POS_W-1:0] POS_RESET = 12'h000;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 8'h00;
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 3'h0;

    // One table entry, also the staging register set
    typedef struct packed {
        logic [POS_W-1:0] vpos;
        logic [POS_W-1:0] hpos;
        logic [LEVEL_W-1:0] lvlOn;
        logic [LEVEL_W-1:0] lvlAbove;
        logic [LEVEL_W-1:0] lvlBelow;
    } dftm_entry_s;

    localparam dftm_entry_s ENTRY_ZERO = '{POS_RESET, POS_RESET,
        LEVEL_RESET, LEVEL_RESET, LEVEL_RESET};

    // Command bits
    typedef struct packed {
        logic clr;
        logic arst;
        logic rd;
        logic wr;
    } dftm_cmd_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CLEAR = 2'b01,
        ST_LOAD = 2'b10
    } dftm_state_e;
endpackage

// ### dftm_mem_if.sv
// Table memory ports shared by controller, correction path and memory
`timescale 1ns/1ps
interface dftm_mem_if import dftm_pkg::*; #(parameter int AW = 4);
    logic aWe;
    logic [AW-1:0] aAddr;
    dftm_entry_s aWdata;
    dftm_entry_s aRdata;
    logic [AW-1:0] bAddr;
    dftm_entry_s bRdata;
    modport mem (input aWe, input aAddr, input aWdata, output aRdata,
        input bAddr, output bRdata);
    modport cmd (output aWe, output aAddr, output aWdata, input aRdata);
    modport corr (output bAddr, input bRdata);
endinterface

// ### dftm_entry_mem.sv
// Two-port defect table memory with registered read data
`timescale 1ns/1ps
module dftm_entry_mem import dftm_pkg::*; #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Memory ports
    dftm_mem_if.mem mem
);
    typedef struct packed {
        dftm_entry_s [DEPTH-1:0] words;
        dftm_entry_s aRdata;
        dftm_entry_s bRdata;
    } dftm_mem_s;

    dftm_mem_s r;
    dftm_mem_s next_r;

    // Port A writes; both ports read old contents on a collision
    always_comb begin
        next_r = r;
        if (mem.aWe) begin
            next_r.words[mem.aAddr] = mem.aWdata;
        end
        next_r.aRdata = r.words[mem.aAddr];
        next_r.bRdata = r.words[mem.bAddr];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign mem.aRdata = r.aRdata;
    assign mem.bRdata = r.bRdata;
endmodule

// ### dftm_level_sub.sv
// Vertical line defect level subtraction on the pixel stream
`timescale 1ns/1ps
module dftm_level_sub import dftm_pkg::*; #(
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Table lookup
    dftm_mem_if.corr corr,
    // Configuration
    input wire logic [SHIFT_W-1:0] levelShift,
    // Pixel in
    input wire logic pixValid,
    input wire logic [PIX_W-1:0] pixData,
    input wire logic [POS_W-1:0] pixRow,
    input wire logic [POS_W-1:0] pixCol,
    input wire logic [AW-1:0] pixEntry,
    // Pixel out
    output logic pixOutValid,
    output logic [PIX_W-1:0] pixOutData
);
    typedef struct packed {
        logic valid1;
        logic [PIX_W-1:0] data1;
        logic [POS_W-1:0] row1;
        logic [POS_W-1:0] col1;
        logic outValid;
        logic [PIX_W-1:0] outData;
    } dftm_sub_s;

    dftm_sub_s r;
    dftm_sub_s next_r;
    dftm_entry_s e;
    logic [LEVEL_W-1:0] lvl;
    logic [PIX_W+1:0] shifted;
    logic [PIX_W+1:0] diff;

    // Entry lookup is issued with the pixel, data arrive one cycle later
    assign corr.bAddr = pixEntry;
    assign e = corr.bRdata;

    // Pick level by row against defect line, shift, subtract, floor at 0
    always_comb begin
        next_r = r;
        next_r.valid1 = pixValid;
        next_r.data1 = pixData;
        next_r.row1 = pixRow;
        next_r.col1 = pixCol;
        if (r.col1 != e.hpos) begin
            lvl = LEVEL_RESET;
        end else if (r.row1 == e.vpos) begin
            lvl = e.lvlOn;
        end else if (r.row1 < e.vpos) begin
            lvl = e.lvlAbove;
        end else begin
            lvl = e.lvlBelow; // [R16]
        end
        // Two spare top bits keep even a shift of 7 from wrapping
        shifted = (PIX_W + 2)'(lvl) << levelShift; // [R14]
        diff = {2'b00, r.data1} - shifted; // [R14]
        next_r.outValid = r.valid1;
        next_r.outData = diff[PIX_W+1] ? '0 : diff[PIX_W-1:0];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pixOutValid = r.outValid;
    assign pixOutData = r.outData;
endmodule

// ### dftm_access_top.sv
// APB access port to the defect correction table memory
// Overview of operation
// R1 - Writing the clear command zeroes every table word.
// R2 - Clear bit reads one while clearing, drops to zero when done.
// R3 - Write or read with address reset set uses table address zero.
// R4 - Address reset bit clears itself when the transfer using it ends.
// R5 - Without address reset, access goes to previous address plus one.
// R6 - Read command fetches one entry and clears itself when done.
// R7 - Fetched entry appears in the entry staging registers.
// R8 - Write command stores staged entry and clears itself when done.
// R9 - Software loads all staging registers before setting write.
// R10 - Vertical position is 12 bits, upper bits read zero.
// R11 - Horizontal position is 12 bits, upper bits read zero.
// R12 - On-line level is 8 bits, upper bits reserved.
// R13 - Above-line level is 8 bits for rows above the defect.
// R14 - Stored level is shifted left by shift amount, then subtracted.
// R15 - Shift amount ranges 0 to 6; software never writes 7.
// R16 - Below-line level is 8 bits for rows below the defect.
// R17 - Software issues a new command only after all command bits clear.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module dftm_access_top import dftm_pkg::*; #(
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pixel stream in
    input wire logic pixValid,
    input wire logic [PIX_W-1:0] pixData,
    input wire logic [POS_W-1:0] pixRow,
    input wire logic [POS_W-1:0] pixCol,
    input wire logic [AW-1:0] pixEntry,
    // Corrected pixel stream out
    output logic pixOutValid,
    output logic [PIX_W-1:0] pixOutData
);
    // Cycles from the clear bit rising to it falling
    localparam int CLR_SPAN = DEPTH + 1;
    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

    typedef struct packed {
        dftm_state_e state;
        dftm_cmd_s cmd;
        dftm_entry_s stage;
        logic [SHIFT_W-1:0] shift;
        logic [AW-1:0] lastAddr;
        logic [AW-1:0] clrCnt;
        logic [APB_DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } dftm_regs_s;

    dftm_regs_s r;
    dftm_regs_s next_r;
    logic accEdge;
    logic accWrite;
    logic cmdWrite;
    logic [AW-1:0] target;

    dftm_mem_if #(.AW(AW)) memIf ();

    // Decode of the register map, shared by read and write paths
    function automatic logic mapped(input logic [APB_AW-1:0] a);
        mapped = (a == OFS_COMMAND) || (a == OFS_VPOS) ||
            (a == OFS_HPOS) || (a == OFS_LVL_ON) ||
            (a == OFS_LVL_ABOVE) || (a == OFS_LVL_BELOW) ||
            (a == OFS_LEVEL_SHIFT);
    endfunction

    // Read data; narrow fields sit low and reserved bits read zero
    function automatic logic [APB_DW-1:0] readMux(
        input logic [APB_AW-1:0] a, input dftm_regs_s s);
        logic [APB_DW-1:0] d;
        d = '0;
        unique case (a)
            OFS_COMMAND: begin
                d[CMD_CLR_BIT] = s.cmd.clr;
                d[CMD_ARST_BIT] = s.cmd.arst;
                d[CMD_RD_BIT] = s.cmd.rd;
                d[CMD_WR_BIT] = s.cmd.wr;
            end
            OFS_VPOS: d[POS_W-1:0] = s.stage.vpos; // [R10]
            OFS_HPOS: d[POS_W-1:0] = s.stage.hpos; // [R11]
            OFS_LVL_ON: d[LEVEL_W-1:0] = s.stage.lvlOn; // [R12]
            OFS_LVL_ABOVE: d[LEVEL_W-1:0] = s.stage.lvlAbove; // [R13]
            OFS_LVL_BELOW: d[LEVEL_W-1:0] = s.stage.lvlBelow; // [R16]
            OFS_LEVEL_SHIFT: d[SHIFT_W-1:0] = s.shift;
            default: d = '0;
        endcase
        return d;
    endfunction

    // APB access edge: the master samples pready high here
    assign accEdge = psel && penable && r.pready;
    assign accWrite = accEdge && pwrite && mapped(paddr);
    assign cmdWrite = accWrite && (paddr == OFS_COMMAND);

    // Address of the next table access, reset or incremented
    assign target = r.cmd.arst ? '0 : AW'(r.lastAddr + 1'b1); // [R3] [R5]

    // Controller, register file and APB answer in one next-state process
    always_comb begin
        next_r = r;
        memIf.aWe = 1'b0;
        memIf.aAddr = target;
        memIf.aWdata = r.stage;
        // No wait state: answer is registered during the setup cycle
        next_r.pready = psel && !penable;
        if (psel && !penable) begin
            next_r.prdata = readMux(paddr, r);
            next_r.pslverr = !mapped(paddr);
        end
        unique case (r.state)
            ST_IDLE: begin
                // Clear outranks write, write outranks read
                if (r.cmd.clr) begin
                    next_r.state = ST_CLEAR;
                    next_r.clrCnt = '0;
                end else if (r.cmd.wr) begin
                    memIf.aWe = 1'b1; // [R8]
                    next_r.lastAddr = target; // [R5]
                    next_r.cmd.wr = 1'b0; // [R8]
                    next_r.cmd.arst = 1'b0; // [R4]
                end else if (r.cmd.rd) begin
                    next_r.lastAddr = target; // [R5]
                    next_r.state = ST_LOAD; // [R6]
                end
            end
            ST_CLEAR: begin
                // One word per cycle; the pixel port stays usable
                memIf.aWe = 1'b1; // [R1]
                memIf.aAddr = r.clrCnt; // [R1]
                memIf.aWdata = ENTRY_ZERO; // [R1]
                next_r.clrCnt = AW'(r.clrCnt + 1'b1);
                if (r.clrCnt == LAST_ADDR) begin
                    next_r.cmd.clr = 1'b0; // [R2]
                    next_r.state = ST_IDLE;
                end
            end
            ST_LOAD: begin
                next_r.stage = memIf.aRdata; // [R7]
                next_r.cmd.rd = 1'b0; // [R6]
                next_r.cmd.arst = 1'b0; // [R4]
                next_r.state = ST_IDLE;
            end
            default: next_r.state = ST_IDLE;
        endcase
        // Software writes last so a set wins over a completion clear
        if (cmdWrite) begin
            next_r.cmd.arst = pwdata[CMD_ARST_BIT];
            next_r.cmd.clr = next_r.cmd.clr | pwdata[CMD_CLR_BIT]; // [R2]
            next_r.cmd.rd = next_r.cmd.rd | pwdata[CMD_RD_BIT];
            next_r.cmd.wr = next_r.cmd.wr | pwdata[CMD_WR_BIT];
        end
        // Staging writes yield to a fetched entry in the same cycle
        if (accWrite && r.state != ST_LOAD) begin
            unique case (paddr)
                OFS_VPOS: next_r.stage.vpos = pwdata[POS_W-1:0]; // [R10]
                OFS_HPOS: next_r.stage.hpos = pwdata[POS_W-1:0]; // [R11]
                OFS_LVL_ON: next_r.stage.lvlOn = pwdata[LEVEL_W-1:0];
                OFS_LVL_ABOVE:
                    next_r.stage.lvlAbove = pwdata[LEVEL_W-1:0];
                OFS_LVL_BELOW:
                    next_r.stage.lvlBelow = pwdata[LEVEL_W-1:0];
                default: next_r.stage = next_r.stage;
            endcase
        end
        // Shift is stored as written; 7 is not guarded here
        if (accWrite && paddr == OFS_LEVEL_SHIFT) begin
            next_r.shift = pwdata[SHIFT_W-1:0];
        end
    end

    // State register; last address starts at all ones so first is zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
            r.lastAddr <= '1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;

    dftm_entry_mem #(.DEPTH(DEPTH), .AW(AW)) uMem (
        .core_clk(core_clk),
        .resetn(resetn),
        .mem(memIf)
    );

    dftm_level_sub #(.AW(AW)) uSub (
        .core_clk(core_clk),
        .resetn(resetn),
        .corr(memIf),
        .levelShift(r.shift),
        .pixValid(pixValid),
        .pixData(pixData),
        .pixRow(pixRow),
        .pixCol(pixCol),
        .pixEntry(pixEntry),
        .pixOutValid(pixOutValid),
        .pixOutData(pixOutData)
    );

    // Clear walks every word with zero data
    a_clear_zero_data: // [R1]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_CLEAR |-> memIf.aWe && memIf.aWdata == ENTRY_ZERO)
        else $error("clear did not write zero");

    // Clear bit holds while busy and drops within the walk length
    a_clear_bit_busy: // [R2]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_CLEAR |-> r.cmd.clr)
        else $error("clear bit low during clear");

    a_clear_bit_done: // [R2]
    assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(r.cmd.clr) && !cmdWrite |-> ##[1:CLR_SPAN] !r.cmd.clr)
        else $error("clear bit did not self clear");

    // Address reset forces table address zero
    a_arst_addr_zero: // [R3]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && !r.cmd.clr && (r.cmd.wr || r.cmd.rd)
        && r.cmd.arst |-> memIf.aAddr == '0)
        else $error("address reset access not at zero");

    // Address reset drops after the transfer that used it
    a_arst_self_clear: // [R4]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && !r.cmd.clr && (r.cmd.wr || r.cmd.rd)
        && r.cmd.arst ##1 !cmdWrite [*2] |-> !r.cmd.arst)
        else $error("address reset bit stuck");

    // Increment from the previously accessed address
    a_incr_next_addr: // [R5]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && !r.cmd.clr && r.cmd.wr && !r.cmd.arst
        |-> memIf.aWe && memIf.aAddr == AW'(r.lastAddr + 1'b1))
        else $error("write not at next address");

    // Read finishes in two cycles and lands in staging
    a_read_self_clear: // [R6]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && !r.cmd.clr && !r.cmd.wr && r.cmd.rd
        ##1 !cmdWrite |=> !r.cmd.rd)
        else $error("read bit did not self clear");

    a_read_to_stage: // [R7]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_LOAD |=> r.stage == $past(memIf.aRdata))
        else $error("fetched entry not staged");

    // Write stores staging and clears next cycle
    a_write_self_clear: // [R8]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && !r.cmd.clr && r.cmd.wr && !cmdWrite
        |-> memIf.aWdata == r.stage ##1 !r.cmd.wr)
        else $error("write bit did not self clear");

    // Reserved upper bits of the vertical position read are zero
    a_pos_reserved: // [R10]
    assert property (@(posedge core_clk) disable iff (!resetn)
        psel && !penable && !pwrite && paddr == OFS_VPOS
        |=> r.prdata[APB_DW-1:POS_W] == '0)
        else $error("reserved position bits not zero");

    // Reserved upper bits of the other staging reads are zero
    a_hpos_reserved: // [R11]
    assert property (@(posedge core_clk) disable iff (!resetn)
        psel && !penable && paddr == OFS_HPOS
        |=> r.prdata[APB_DW-1:POS_W] == '0)
        else $error("reserved horizontal bits not zero");

    a_level_on_reserved: // [R12]
    assert property (@(posedge core_clk) disable iff (!resetn)
        psel && !penable && paddr == OFS_LVL_ON
        |=> r.prdata[APB_DW-1:LEVEL_W] == '0)
        else $error("reserved on-line level bits not zero");

    a_above_reserved: // [R13]
    assert property (@(posedge core_clk) disable iff (!resetn)
        psel && !penable && paddr == OFS_LVL_ABOVE
        |=> r.prdata[APB_DW-1:LEVEL_W] == '0)
        else $error("reserved above level bits not zero");

    a_below_reserved: // [R16]
    assert property (@(posedge core_clk) disable iff (!resetn)
        psel && !penable && paddr == OFS_LVL_BELOW
        |=> r.prdata[APB_DW-1:LEVEL_W] == '0)
        else $error("reserved below level bits not zero");

    // Clear starts its walk at word zero
    a_clear_from_zero: // [R1]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && r.cmd.clr
        |=> r.state == ST_CLEAR && r.clrCnt == '0)
        else $error("clear did not start at word zero");

    // Last word ends the clear unless software sets it again
    a_clear_end_drop: // [R2]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_CLEAR && r.clrCnt == LAST_ADDR
        && !(cmdWrite && pwdata[CMD_CLR_BIT])
        |=> r.state == ST_IDLE && !r.cmd.clr)
        else $error("clear bit not dropped after last word");

    // A debug read never disturbs the table
    a_read_no_store: // [R6]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_LOAD |-> !memIf.aWe)
        else $error("table written during a read");

    // Read picks its address like a write, then fetches
    a_read_enters_load: // [R6]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && !r.cmd.clr && !r.cmd.wr && r.cmd.rd
        |=> r.state == ST_LOAD)
        else $error("read did not start a fetch");

    a_read_arst_zero: // [R3]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && !r.cmd.clr && !r.cmd.wr && r.cmd.rd
        && r.cmd.arst |=> r.lastAddr == '0)
        else $error("address reset read not at zero");

    a_read_incr_addr: // [R5]
    assert property (@(posedge core_clk) disable iff (!resetn)
        r.state == ST_IDLE && !r.cmd.clr && !r.cmd.wr && r.cmd.rd
        && !r.cmd.arst |=> r.lastAddr == AW'($past(r.lastAddr) + 1'b1))
        else $error("read not at next address");
endmodule

// ### tb_dftm_access_top.sv
// Self-checking bench for the defect table APB access block
`timescale 1ns/1ps
module tb_dftm_access_top import dftm_pkg::*; ;
    logic core_clk;
    logic resetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic pixValid;
    logic [PIX_W-1:0] pixData;
    logic [POS_W-1:0] pixRow;
    logic [POS_W-1:0] pixCol;
    logic [3:0] pixEntry;
    logic pixOutValid;
    logic [PIX_W-1:0] pixOutData;
    int errCount;
    int checksDone;
    int cycles;

    dftm_access_top #(.DEPTH(16)) uut (
        .core_clk(core_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pixValid(pixValid), .pixData(pixData),
        .pixRow(pixRow), .pixCol(pixCol), .pixEntry(pixEntry),
        .pixOutValid(pixOutValid), .pixOutData(pixOutData)
    );

    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    // Report and stop; reached from the main flow or the hang guard
    task automatic giveVerdict();
        $display("Checks %0d, errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            giveVerdict();
        end
    end

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apbXfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // No local limit: only the hang guard ends a stalled wait
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apbXfer(1'b1, a, d, rd, err);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apbXfer(1'b0, a, 32'h0, rd, err);
        chk($sformatf("reg %h", a), exp, rd);
    endtask

    // Poll until every command bit reads back zero
    task automatic waitIdle();
        logic [31:0] rd;
        logic err;
        int n;
        n = 0;
        do begin
            apbXfer(1'b0, OFS_COMMAND, 32'h0, rd, err);
            n++;
        end while (rd[4:0] !== 5'h00 && n < 60);
        chk("command idle", 32'h0, rd);
    endtask

    task automatic cmd(input logic [7:0] c);
        wr(OFS_COMMAND, {24'h0, c});
        waitIdle();
    endtask

    task automatic loadEntry(logic [11:0] v, logic [11:0] h,
        logic [7:0] on, logic [7:0] ab, logic [7:0] be);
        wr(OFS_VPOS, {20'h0, v});
        wr(OFS_HPOS, {20'h0, h});
        wr(OFS_LVL_ON, {24'h0, on});
        wr(OFS_LVL_ABOVE, {24'h0, ab});
        wr(OFS_LVL_BELOW, {24'h0, be});
    endtask

    task automatic checkEntry(logic [11:0] v, logic [11:0] h,
        logic [7:0] on, logic [7:0] ab, logic [7:0] be);
        rdChk(OFS_VPOS, {20'h0, v});
        rdChk(OFS_HPOS, {20'h0, h});
        rdChk(OFS_LVL_ON, {24'h0, on});
        rdChk(OFS_LVL_ABOVE, {24'h0, ab});
        rdChk(OFS_LVL_BELOW, {24'h0, be});
    endtask

    // Reset values and an unmapped address
    task automatic tReset();
        logic [31:0] rd;
        logic err;
        for (int a = 0; a <= 8'h18; a += 4) begin
            rdChk(8'(a), 32'h0);
        end
        apbXfer(1'b0, 8'h40, 32'h0, rd, err);
        chk("unmapped slverr", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask

    // Reserved upper bits read zero
    task automatic tWidths();
        loadEntry(12'hfff, 12'hfff, 8'hff, 8'hff, 8'hff);
        wr(OFS_VPOS, 32'hffff_ffff);
        wr(OFS_HPOS, 32'hffff_ffff);
        wr(OFS_LVL_ON, 32'hffff_ffff);
        wr(OFS_LVL_ABOVE, 32'hffff_ffff);
        wr(OFS_LVL_BELOW, 32'hffff_ffff);
        checkEntry(12'hfff, 12'hfff, 8'hff, 8'hff, 8'hff);
    endtask

    // Write two entries, read them back by address reset and increment
    task automatic tWriteRead();
        loadEntry(12'h123, 12'h456, 8'h11, 8'h22, 8'h33);
        cmd(8'h05);
        loadEntry(12'hfed, 12'hcba, 8'h44, 8'h55, 8'h66);
        cmd(8'h01);
        loadEntry(12'h0, 12'h0, 8'h0, 8'h0, 8'h0);
        cmd(8'h06);
        checkEntry(12'h123, 12'h456, 8'h11, 8'h22, 8'h33);
        cmd(8'h02);
        checkEntry(12'hfed, 12'hcba, 8'h44, 8'h55, 8'h66);
    endtask

    // Clear busy flag, then both written words read back zero
    task automatic tClear();
        wr(OFS_COMMAND, 32'h10);
        rdChk(OFS_COMMAND, 32'h10);
        waitIdle();
        cmd(8'h06);
        checkEntry(12'h0, 12'h0, 8'h0, 8'h0, 8'h0);
        cmd(8'h02);
        checkEntry(12'h0, 12'h0, 8'h0, 8'h0, 8'h0);
    endtask

    function automatic logic [31:0] subFloor(int d, int lvl, int s);
        return (d > (lvl << s)) ? 32'(d - (lvl << s)) : 32'h0;
    endfunction

    // One pixel in, result two edges later
    task automatic pix(logic [11:0] r, logic [11:0] c, logic [3:0] e,
        logic [13:0] d, logic [31:0] exp);
        @(posedge core_clk);
        pixValid <= 1'b1;
        pixRow <= r;
        pixCol <= c;
        pixEntry <= e;
        pixData <= d;
        @(posedge core_clk);
        pixValid <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("pixel valid", 32'h1, {31'h0, pixOutValid});
        chk("pixel data", exp, {18'h0, pixOutData});
    endtask

    // Level subtraction across shifts, rows and columns
    task automatic tPixel();
        loadEntry(12'd10, 12'd20, 8'd3, 8'd5, 8'd7);
        cmd(8'h05);
        loadEntry(12'd10, 12'd30, 8'd9, 8'd9, 8'd9);
        cmd(8'h01);
        for (int s = 0; s <= 6; s++) begin
            wr(OFS_LEVEL_SHIFT, 32'(s));
            pix(12'd10, 12'd20, 4'd0, 14'd2000,
                subFloor(2000, 3, s));
        end
        wr(OFS_LEVEL_SHIFT, 32'h2);
        pix(12'd9, 12'd20, 4'd0, 14'd2000, 32'd1980);
        pix(12'd11, 12'd20, 4'd0, 14'd2000, 32'd1972);
        pix(12'd10, 12'd21, 4'd0, 14'd2000, 32'd2000);
        pix(12'd10, 12'd30, 4'd1, 14'd2000, 32'd1964);
        pix(12'd11, 12'd20, 4'd0, 14'd10, 32'd0);
    endtask

    // Main sequence
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pixValid = 1'b0;
        pixData = '0;
        pixRow = '0;
        pixCol = '0;
        pixEntry = '0;
        errCount = 0;
        checksDone = 0;
        cycles = 0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        tReset();
        tWidths();
        tWriteRead();
        tClear();
        tPixel();
        giveVerdict();
    end
endmodule
